// [hdl/dadj_dec_pkg.sv]
// Package with encodings, field positions, reset values and phase codes for the execution block.
package dadj_dec_pkg;
    localparam logic [15:0] decimal_adjust_code = 16'h0007;
    localparam logic [5:0] decrement_file_prefix = 6'h01;
    localparam logic [5:0] decrement_skip_prefix = 6'h0b;
    localparam int opcode_msb = 15;
    localparam int opcode_lsb = 10;
    localparam int dest_bit = 9;
    localparam int access_bit = 8;
    localparam int addr_msb = 7;
    localparam logic [7:0] indexed_offset_limit = 8'h5f;
    localparam logic [7:0] access_bank_split = 8'h60;
    localparam logic [3:0] access_high_bank = 4'hf;
    localparam logic [7:0] working_reset = 8'h00;
    localparam logic [4:0] status_reset = 5'h00;
    localparam logic [3:0] bcd_adjust = 4'h6;
    localparam logic [3:0] bcd_digit_max = 4'h9;

    typedef enum logic [1:0] {
        phase_decode = 2'b00,
        phase_read = 2'b01,
        phase_process = 2'b10,
        phase_write = 2'b11
    } phase_t;

    typedef enum logic [1:0] {
        op_none = 2'b00,
        op_decimal_adjust = 2'b01,
        op_dec = 2'b10,
        op_dec_skip = 2'b11
    } op_t;
endpackage

// [hdl/operand_address.sv]
// Operand address former: access bank, banked and indexed literal offset addressing.
`timescale 1ns/1ps
module operand_address (
    input wire logic [7:0] file_addr,
    input wire logic bank_access,
    input wire logic extended_enable,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    output logic [11:0] data_addr,
    output logic indexed_mode
);
    import dadj_dec_pkg::*;

    always_comb begin
        indexed_mode = 1'b0;
        if (bank_access) begin
            data_addr = {bank_select_register, file_addr}; // [RULE6]
        end else if (extended_enable && file_addr <= indexed_offset_limit) begin
            indexed_mode = 1'b1;
            data_addr = index_base + {4'h0, file_addr}; // [RULE7]
        end else if (file_addr < access_bank_split) begin
            data_addr = {4'h0, file_addr}; // [RULE6]
        end else begin
            data_addr = {access_high_bank, file_addr}; // [RULE6]
        end
    end
endmodule

// [hdl/dadj_dec_exec.sv]
// Four-phase execution unit for decimal adjust, decrement and decrement-skip.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Decimal adjust runs in one cycle of four phases: decode, read working register, process, write working register.
// RULE2: Decimal adjust adds 6 to a low digit above 9 or with digit carry, adds 6 plus digit carry to a high digit above 9 or with carry, and changes only carry.
// RULE3: Decrement subtracts one from the addressed file register and sends the result to the chosen destination.
// RULE4: Decrement updates carry, digit carry, negative, overflow and zero from its subtraction.
// RULE5: Destination bit 0 writes the working register and 1 writes the file register back.
// RULE6: Bank-access bit 0 uses the access bank and 1 uses the bank select register for the bank.
// RULE7: With extended set on, bank-access 0 and address at most 95, indexed literal offset addressing is used.
// RULE8: Decrement is one word and one cycle of decode, read file, process, write destination.
// RULE9: Decrement and decrement-skip take an 8-bit file address plus destination and bank-access bits.
// RULE10: Decrement-skip decrements the file register and skips the next instruction when the result is zero.
// RULE11: After a decrement zero is set exactly for a zero result and negative equals result bit 7.
module dadj_dec_exec (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic extended_enable,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    input wire logic [7:0] mem_rdata,
    output logic instr_ready,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic [7:0] working_register,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic negative_flag,
    output logic overflow_flag,
    output logic zero_flag,
    output logic skip_next,
    output logic indexed_used,
    output dadj_dec_pkg::phase_t phase
);
    import dadj_dec_pkg::*;

    phase_t phase_reg;
    op_t op_reg;
    op_t op_next;
    logic dest_reg;
    logic [7:0] operand_reg;
    logic [7:0] result_reg;
    logic [4:0] flags_next;
    logic [11:0] addr_calc;
    logic indexed_calc;
    logic [7:0] adjust_result;
    logic adjust_carry;
    logic [7:0] dec_result;
    logic [4:0] low_sum;
    logic [4:0] high_sum;

    operand_address u_addr (
        .file_addr(instr_word[addr_msb:0]), // [RULE9]
        .bank_access(instr_word[access_bit]),
        .extended_enable(extended_enable),
        .bank_select_register(bank_select_register),
        .index_base(index_base),
        .data_addr(addr_calc),
        .indexed_mode(indexed_calc)
    );

    always_comb begin
        op_next = op_none;
        if (instr_word == decimal_adjust_code) begin
            op_next = op_decimal_adjust;
        end else if (instr_word[opcode_msb:opcode_lsb] == decrement_file_prefix) begin
            op_next = op_dec;
        end else if (instr_word[opcode_msb:opcode_lsb] == decrement_skip_prefix) begin
            op_next = op_dec_skip;
        end
    end

    // The high digit test sees the carry out of the low digit fix, as a packed BCD add would.
    always_comb begin
        low_sum = {1'b0, operand_reg[3:0]};
        if (operand_reg[3:0] > bcd_digit_max || digit_carry_flag) begin
            low_sum = {1'b0, operand_reg[3:0]} + {1'b0, bcd_adjust}; // [RULE2]
        end
        high_sum = {1'b0, operand_reg[7:4]} + {4'h0, low_sum[4]};
        if (high_sum > {1'b0, bcd_digit_max} || carry_flag) begin
            high_sum = high_sum + {1'b0, bcd_adjust}; // [RULE2]
        end
        adjust_result = {high_sum[3:0], low_sum[3:0]};
        adjust_carry = high_sum[4] | carry_flag;
    end

    // Decrement is an add of all ones, so carry means no borrow as in the core's subtract.
    always_comb begin
        dec_result = operand_reg - 8'h01; // [RULE3]
        flags_next[0] = operand_reg != 8'h00; // [RULE4]
        flags_next[1] = operand_reg[3:0] != 4'h0; // [RULE4]
        flags_next[2] = dec_result[7]; // [RULE11]
        flags_next[3] = operand_reg == 8'h80; // [RULE4]
        flags_next[4] = dec_result == 8'h00; // [RULE11]
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_reg <= phase_decode;
        end else if (phase_reg != phase_decode || instr_valid) begin
            phase_reg <= phase_t'(phase_reg + 2'b01); // [RULE1] [RULE8]
        end
    end

    // Operand fields are latched at decode so the front end may move on at once.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_reg <= op_none;
            dest_reg <= 1'b0;
        end else if (phase_reg == phase_decode && instr_valid) begin
            op_reg <= op_next;
            dest_reg <= instr_word[dest_bit]; // [RULE9]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mem_addr <= 12'h000;
            indexed_used <= 1'b0;
        end else if (phase_reg == phase_decode && instr_valid) begin
            mem_addr <= addr_calc; // [RULE6] [RULE7]
            indexed_used <= indexed_calc && op_next inside {op_dec, op_dec_skip}; // [RULE7]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            operand_reg <= working_reset;
            result_reg <= working_reset;
        end else if (phase_reg == phase_read) begin
            operand_reg <= (op_reg == op_decimal_adjust) ? working_register
                : mem_rdata; // [RULE1] [RULE8]
        end else if (phase_reg == phase_process) begin
            result_reg <= (op_reg == op_decimal_adjust) ? adjust_result : dec_result;
        end
    end

    // File read is requested in decode so data is present during the read phase.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mem_rd <= 1'b0;
        end else begin
            mem_rd <= phase_reg == phase_decode && instr_valid
                && op_next inside {op_dec, op_dec_skip}; // [RULE8]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mem_wr <= 1'b0;
        end else begin
            mem_wr <= phase_reg == phase_process && dest_reg
                && op_reg inside {op_dec, op_dec_skip}; // [RULE5]
        end
    end

    // Write data is kept after the strobe, so a slow memory may still latch it late.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mem_wdata <= working_reset;
        end else if (phase_reg == phase_process) begin
            mem_wdata <= dec_result; // [RULE3]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            working_register <= working_reset;
        end else if (phase_reg == phase_process) begin
            if (op_reg == op_decimal_adjust) begin
                working_register <= adjust_result; // [RULE1]
            end else if (op_reg != op_none && !dest_reg) begin
                working_register <= dec_result; // [RULE5]
            end
        end
    end

    // Flags land with the write phase; decrement-skip leaves status alone.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {zero_flag, overflow_flag, negative_flag, digit_carry_flag, carry_flag} <= status_reset;
        end else if (phase_reg == phase_process) begin
            if (op_reg == op_decimal_adjust) begin
                carry_flag <= adjust_carry; // [RULE2]
            end else if (op_reg == op_dec) begin
                {zero_flag, overflow_flag, negative_flag, digit_carry_flag, carry_flag}
                    <= flags_next; // [RULE4] [RULE11]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            skip_next <= 1'b0;
        end else begin
            skip_next <= phase_reg == phase_process && op_reg == op_dec_skip
                && dec_result == 8'h00; // [RULE10]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            instr_ready <= 1'b0;
        end else begin
            instr_ready <= phase_reg == phase_write || (phase_reg == phase_decode && !instr_valid);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase <= phase_decode;
        end else begin
            phase <= phase_reg;
        end
    end

    logic unused_result;
    assign unused_result = ^result_reg;
endmodule

// [verification/data_mem_model.sv]
// Data memory model that answers the unit's reads and takes its writes.
`timescale 1ns/1ps
module data_mem_model (
    input wire logic core_clk,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    logic rd_reg = 1'b0;
    initial foreach (mem[i]) mem[i] = 8'(i * 37);
    always @(posedge core_clk) begin
        rd_reg <= mem_rd;
        if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
    // Outside the read window the bus shows the inverse, so stale data never looks valid.
    assign mem_rdata = (mem_rd || rd_reg) ? mem[mem_addr] : ~mem[mem_addr];
endmodule

// [verification/dadj_dec_exec_monitor.sv]
// Checker for the decimal adjust and decrement execution unit.
`timescale 1ns/1ps
module dadj_dec_exec_monitor
import dadj_dec_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] working_register,
    input wire logic negative_flag,
    input wire logic zero_flag,
    input wire logic skip_next,
    input wire phase_t phase
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence read_then_write; mem_rd ##2 mem_wr; endsequence
    rd_pulse_a: assert property (mem_rd |=> !mem_rd) else $error("read strobe too long");
    wr_order_a: assert property (mem_wr |-> $past(mem_rd, 2)) else $error("write without read");
    wr_value_a: assert property (read_then_write |-> mem_wdata == $past(mem_rdata) - 8'h01)
        else $error("written value wrong");
    skip_cause_a: assert property (skip_next |-> $past(mem_rdata) == 8'h01)
        else $error("skip without zero result");
    skip_pulse_a: assert property (skip_next |=> !skip_next) else $error("skip too long");
    phase_step_a: assert property (phase != phase_decode |=> 2'(phase) == 2'($past(phase)) + 2'd1)
        else $error("phase order wrong");
    zero_flag_a: assert property (!$past(rst) && $changed(zero_flag) |-> zero_flag ==
        ((mem_wr ? mem_wdata : working_register) == 8'h00)) else $error("zero flag wrong");
    neg_flag_a: assert property (!$past(rst) && $changed(negative_flag) |-> negative_flag ==
        (mem_wr ? mem_wdata[7] : working_register[7])) else $error("negative flag wrong");
endmodule
bind dadj_dec_exec dadj_dec_exec_monitor i_monitor (.core_clk, .rst, .mem_rdata, .mem_rd,
    .mem_wr, .mem_wdata, .working_register, .negative_flag, .zero_flag, .skip_next, .phase);

// [verification/tb.sv]
// Random and corner-case bench for the decimal adjust and decrement unit.
`timescale 1ns/1ps
module tb;
    import dadj_dec_pkg::*;
    logic core_clk = 0, rst = 1, instr_valid = 0, extended_enable = 0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] bank_select_register = 4'h0;
    logic [11:0] index_base = 12'h000, mem_addr, r;
    logic [7:0] mem_rdata, mem_wdata, working_register, ew = 8'h00;
    logic [7:0] cv [6] = '{8'h00, 8'h01, 8'h80, 8'h10, 8'h01, 8'h05};
    logic [7:0] dv [2] = '{8'ha5, 8'hce};
    logic [7:0] dx [2] = '{8'h05, 8'h34};
    logic [4:0] ef = 5'h00, fl;
    logic instr_ready, mem_rd, mem_wr, carry_flag, digit_carry_flag, negative_flag;
    logic overflow_flag, zero_flag, skip_next, indexed_used;
    phase_t phase;
    int errors = 0, checks_done = 0, seed = 57, cycles = 0;
    assign fl = {carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag};
    always #4 core_clk = ~core_clk;
    dadj_dec_exec i_dut (.core_clk, .rst, .instr_valid, .instr_word, .extended_enable,
        .bank_select_register, .index_base, .mem_rdata, .instr_ready, .mem_addr, .mem_rd,
        .mem_wr, .mem_wdata, .working_register, .carry_flag, .digit_carry_flag,
        .negative_flag, .overflow_flag, .zero_flag, .skip_next, .indexed_used, .phase);
    data_mem_model i_mem (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    task chk(input logic [11:0] g, input logic [11:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task start(input logic [15:0] w);
        instr_word = w;
        instr_valid = 1'b1;
        @(negedge core_clk);
        instr_valid = 1'b0;
    endtask
    function automatic logic [11:0] exp_addr(input logic [7:0] f, input logic a);
        if (a) return {bank_select_register, f};
        if (extended_enable && f <= 8'h5f) return index_base + 12'(f);
        return (f < 8'h60) ? {4'h0, f} : {4'hf, f};
    endfunction
    task automatic dec(input logic s, input logic d, input logic a, input logic [7:0] f);
        logic [11:0] ad;
        logic [7:0] v;
        logic [7:0] res;
        ad = exp_addr(f, a);
        start({s ? 6'h0b : 6'h01, d, a, f});
        v = i_mem.mem[ad];
        res = v - 8'h01;
        chk(mem_addr, ad);
        chk(12'(mem_rd), 12'h001);
        chk(12'(instr_ready), 12'h000);
        repeat (2) @(negedge core_clk);
        if (!s) ef = {v != 8'h00, v[3:0] != 4'h0, res[7], v == 8'h80, res == 8'h00};
        if (!d) ew = res;
        chk(12'(mem_wr), 12'(d));
        chk(12'(phase), 12'h002);
        if (d) chk(12'(mem_wdata), 12'(res));
        chk(12'(working_register), 12'(ew));
        chk(12'(fl), 12'(ef));
        chk(12'(skip_next), 12'(s && res == 8'h00));
        chk(12'(indexed_used), 12'(!a && extended_enable && f <= 8'h5f));
        @(negedge core_clk);
        chk(12'(instr_ready), 12'h001);
    endtask
    task automatic adjust();
        logic [8:0] t;
        logic hi;
        t = {1'b0, ew};
        if (t[3:0] > 4'h9 || ef[3]) t = t + 9'h006;
        hi = t[8] || t[7:4] > 4'h9 || ef[4];
        if (hi) t = t + 9'h060;
        start(16'h0007);
        chk(12'(mem_rd), 12'h000);
        repeat (2) @(negedge core_clk);
        ew = t[7:0];
        ef[4] = ef[4] | hi;
        chk(12'(working_register), 12'(ew));
        chk(12'(fl), 12'(ef));
        @(negedge core_clk);
    endtask
    task automatic no_op(input logic [15:0] w);
        start(w);
        chk(12'({mem_rd, instr_ready}), 12'h000);
        repeat (2) @(negedge core_clk);
        chk(12'({mem_wr, skip_next, working_register}), 12'(ew));
        chk(12'(fl), 12'(ef));
        @(negedge core_clk);
    endtask
    task chk_reset();
        chk(12'({working_register, fl[4:1]}), 12'h000);
        chk(12'({mem_wdata, fl[0], mem_rd, mem_wr, skip_next}), 12'h000);
        chk(mem_addr, 12'h000);
        chk(12'({indexed_used, phase}), 12'h000);
        chk(12'(instr_ready), 12'h001);
    endtask
    task test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // The ceiling is several times the length of the planned run.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        chk_reset();
        foreach (cv[i]) begin
            i_mem.mem[12'h020] = cv[i];
            dec(i > 3, 1'b1, 1'b0, 8'h20);
        end
        extended_enable = 1'b1;
        dec(1'b0, 1'b0, 1'b0, 8'h5f);
        dec(1'b0, 1'b0, 1'b0, 8'h60);
        dec(1'b1, 1'b0, 1'b1, 8'hff);
        adjust();
        foreach (dv[i]) begin
            i_mem.mem[12'h021] = 8'h00;
            i_mem.mem[12'h022] = dv[i] + 8'h01;
            dec(1'b0, 1'b1, 1'b0, 8'h21);
            dec(1'b1, 1'b0, 1'b0, 8'h22);
            adjust();
            chk(12'({3'h0, carry_flag, working_register}), {4'h1, dx[i]});
        end
        no_op(16'h0006);
        no_op(16'h0800);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        ew = 8'h00;
        ef = 5'h00;
        @(negedge core_clk);
        chk_reset();
        repeat (80) begin
            bank_select_register = 4'($random(seed));
            extended_enable = 1'($random(seed));
            index_base = 12'($random(seed));
            r = 12'($random(seed));
            if (r[11:10] == 2'b00) adjust();
            else dec(r[8], r[9], r[10], r[7:0]);
        end
        test_done();
    end
endmodule
